// *** logic/nfc_pkg.sv ***
// Overview of operation
// - Command byte latches on write strobe rising edge while command latch is high.
// - Address byte latches on write strobe rising edge while address latch is high.
// - A full address is five consecutive address write cycles.
// - Column goes low byte first; cycle two upper three lines low.
// - Row bits 0-5 pick the page; cycles three and four carry row bits 0-15.
// - Row bits 6-16 pick the block; cycle five carries row bit 16 only.
// - End a cached single-plane series with load 80h then confirm 10h.
// - A series ended by 15h needs 70h polling until ready, then FFh reset.
// - Cached multi-plane series ends 81h-10h; 81h-15h needs the same recovery.
// - Eight port lines carry commands, addresses and data, told apart by latches.
// - Cached page program is 80h-15h; plain page program is 80h-10h.
// - Multi-plane or multi-block status polling uses 71h, accepted while busy.
`default_nettype none
package nfc_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int T_WP_NS = 12;
    localparam int T_WH_NS = 10;
    localparam int T_REA_NS = 20;
    localparam int T_REH_NS = 10;
    localparam int T_WB_NS = 100;
    localparam int T_WHR_NS = 60;
    localparam int T_WW_NS = 100;
    localparam logic [4:0] W_LO_CYC = 5'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [4:0] W_HI_CYC = 5'((T_WH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [4:0] REA_CYC = 5'((T_REA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Two sync stages plus the output register sit between strobe and sample
    localparam logic [4:0] R_LO_CYC = REA_CYC + 5'd3;
    localparam logic [4:0] R_HI_CYC = 5'((T_REH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [4:0] WB_CYC = 5'((T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [4:0] WHR_CYC = 5'((T_WHR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [4:0] CE_SETUP_CYC = 5'((T_WW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int PAGE_BYTES = 4352;
    localparam int MAIN_BYTES = 4096;
    localparam int SPARE_BYTES = 256;
    localparam int PAGES_PER_BLOCK = 64;
    localparam int BLOCK_COUNT = 2048;
    localparam logic [2:0] ADDR_FIRST_ROW = 3'd2;
    localparam logic [2:0] ADDR_LAST = 3'd4;
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 32;
    localparam logic [7:0] CMD_READ_1 = 8'h00;
    localparam logic [7:0] CMD_READ_2 = 8'h30;
    localparam logic [7:0] CMD_LOAD = 8'h80;
    localparam logic [7:0] CMD_LOAD_MP = 8'h81;
    localparam logic [7:0] CMD_CONFIRM = 8'h10;
    localparam logic [7:0] CMD_CONFIRM_CACHE = 8'h15;
    localparam logic [7:0] CMD_ERASE_1 = 8'h60;
    localparam logic [7:0] CMD_ERASE_2 = 8'hD0;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_STATUS_MP = 8'h71;
    localparam logic [7:0] CMD_RESET = 8'hFF;

    typedef enum logic [3:0] {
        OP_READ, OP_PROG, OP_PROG_CACHE, OP_PROG_MP, OP_PROG_MP_CACHE,
        OP_ERASE, OP_STATUS, OP_STATUS_MP, OP_RESET
    } nfc_op_t;

    typedef struct packed {
        nfc_op_t op;
        logic [12:0] column_bits;
        logic [16:0] row;
        logic [12:0] len;
    } nfc_req_t;

    function automatic logic [7:0] nfc_first_cmd(input nfc_op_t op);
        unique case (op)
            OP_READ: return CMD_READ_1;
            OP_PROG, OP_PROG_CACHE: return CMD_LOAD;
            OP_PROG_MP, OP_PROG_MP_CACHE: return CMD_LOAD_MP;
            OP_ERASE: return CMD_ERASE_1;
            OP_STATUS: return CMD_STATUS;
            OP_STATUS_MP: return CMD_STATUS_MP;
            default: return CMD_RESET;
        endcase
    endfunction

    function automatic logic [7:0] nfc_second_cmd(input nfc_op_t op);
        unique case (op)
            OP_READ: return CMD_READ_2;
            OP_PROG_CACHE, OP_PROG_MP_CACHE: return CMD_CONFIRM_CACHE;
            OP_ERASE: return CMD_ERASE_2;
            default: return CMD_CONFIRM;
        endcase
    endfunction

    function automatic logic [7:0] nfc_addr_byte(input logic [2:0] idx, input nfc_req_t q);
        unique case (idx)
            3'd0: return q.column_bits[7:0];
            3'd1: return {3'h0, q.column_bits[12:8]};
            3'd2: return q.row[7:0];
            3'd3: return q.row[15:8];
            default: return {7'h00, q.row[16]};
        endcase
    endfunction
endpackage
`default_nettype wire

// *** logic/nfc_ctrl.sv ***
`default_nettype none
module nfc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic in_rdy;
        logic out_vld;
    } nfc_fifo_st_t;
    nfc_fifo_st_t r_reg;
    nfc_fifo_st_t r_next;
    logic push;
    logic pop;

    always_comb begin
        r_next = r_reg;
        push = in_valid_in && r_reg.in_rdy;
        pop = out_ready_in && r_reg.out_vld;
        if (push) begin
            r_next.mem[r_reg.wp] = in_data_in;
            r_next.wp = (r_reg.wp == AW'(DEPTH - 1)) ? '0 : r_reg.wp + 1'b1;
        end
        if (pop) begin
            r_next.rp = (r_reg.rp == AW'(DEPTH - 1)) ? '0 : r_reg.rp + 1'b1;
        end
        r_next.cnt = r_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        r_next.in_rdy = r_next.cnt != (AW + 1)'(DEPTH);
        r_next.out_vld = r_next.cnt != '0;
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            r_reg <= '0;
            r_reg.in_rdy <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign in_ready_out = r_reg.in_rdy;
    assign out_valid_out = r_reg.out_vld;
    assign out_data_out = r_reg.mem[r_reg.rp];
endmodule

module nfc_ctrl
    import nfc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Request port
    input wire logic req_valid_in,
    input wire nfc_req_t req_in,
    output logic req_ready_out,
    output logic done_out,
    input wire logic write_enable_in,
    // Program data stream
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    input wire logic [7:0] wr_data_in,
    // Read data stream
    output logic rd_valid_out,
    output logic [7:0] rd_data_out,
    // Flash pins
    output logic nand_ce_n_out,
    output logic nand_cle_out,
    output logic nand_ale_out,
    output logic nand_we_n_out,
    output logic read_strobe_n_out,
    output logic nand_wp_n_out,
    output logic [7:0] port_lines_out,
    output logic port_lines_oe_out,
    input wire logic [7:0] port_lines_in,
    input wire logic ready_busy_n_in
);
    typedef enum logic [3:0] {
        S_IDLE, S_SETUP, S_CMD1, S_ADDR, S_DATA, S_CMD2, S_WB, S_RDY, S_WHR, S_READ, S_DONE
    } nfc_st_t;

    typedef struct packed {
        nfc_st_t st;
        nfc_req_t req;
        logic [4:0] cnt;
        logic [2:0] idx;
        logic [12:0] nbytes;
        logic ce_n;
        logic cle;
        logic ale;
        logic we_n;
        logic re_n;
        logic wp_n;
        logic [7:0] dout;
        logic oe;
        logic [7:0] rdat;
        logic rval;
        logic idle;
        logic done;
        logic [7:0] io_s1;
        logic [7:0] io_s2;
        logic rb_s1;
        logic rb_s2;
    } nfc_ctrl_st_t;

    nfc_ctrl_st_t r_reg;
    nfc_ctrl_st_t r_next;
    logic fifo_valid;
    logic fifo_pop;
    logic [7:0] fifo_data;
    logic wr_last;
    logic rd_end;
    logic is_prog;
    logic is_status;

    nfc_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .in_valid_in(wr_valid_in),
        .in_ready_out(wr_ready_out),
        .in_data_in(wr_data_in),
        .out_valid_out(fifo_valid),
        .out_ready_in(fifo_pop),
        .out_data_out(fifo_data)
    );

    always_comb begin
        r_next = r_reg;
        r_next.io_s1 = port_lines_in;
        r_next.io_s2 = r_reg.io_s1;
        r_next.rb_s1 = ready_busy_n_in;
        r_next.rb_s2 = r_reg.rb_s1;
        r_next.rval = 1'b0;
        r_next.done = 1'b0;
        // Protect stays asserted unless software opens it
        r_next.wp_n = write_enable_in;
        r_next.cnt = r_reg.cnt + 5'd1;
        fifo_pop = 1'b0;
        wr_last = r_reg.cnt == W_LO_CYC + W_HI_CYC - 5'd1;
        rd_end = r_reg.cnt == R_LO_CYC + R_HI_CYC - 5'd1;
        is_prog = r_reg.req.op inside {OP_PROG, OP_PROG_CACHE, OP_PROG_MP, OP_PROG_MP_CACHE};
        is_status = r_reg.req.op inside {OP_STATUS, OP_STATUS_MP};
        if (r_reg.st inside {S_CMD1, S_ADDR, S_DATA, S_CMD2}) begin
            if (r_reg.cnt == 5'd0) begin
                r_next.we_n = 1'b0;
            end
            if (r_reg.cnt == W_LO_CYC) begin
                r_next.we_n = 1'b1;
            end
        end
        unique case (r_reg.st)
            S_IDLE: begin
                r_next.cnt = 5'd0;
                if (req_valid_in) begin
                    r_next.req = req_in;
                    r_next.ce_n = 1'b0;
                    r_next.idle = 1'b0;
                    r_next.nbytes = 13'h0000;
                    r_next.st = S_SETUP;
                end
            end
            S_SETUP: begin
                if (r_reg.cnt == CE_SETUP_CYC - 5'd1) begin
                    r_next.cnt = 5'd0;
                    r_next.st = S_CMD1;
                end
            end
            S_CMD1: begin
                if (r_reg.cnt == 5'd0) begin
                    r_next.cle = 1'b1;
                    r_next.oe = 1'b1;
                    r_next.dout = nfc_first_cmd(r_reg.req.op);
                end
                if (wr_last) begin
                    r_next.cnt = 5'd0;
                    r_next.cle = 1'b0;
                    r_next.oe = 1'b0;
                    if (r_reg.req.op == OP_RESET) begin
                        r_next.st = S_WB;
                    end else if (is_status) begin
                        r_next.st = S_WHR;
                    end else begin
                        // Erase carries only the three row cycles
                        r_next.idx = (r_reg.req.op == OP_ERASE) ? ADDR_FIRST_ROW : 3'd0;
                        r_next.st = S_ADDR;
                    end
                end
            end
            S_ADDR: begin
                if (r_reg.cnt == 5'd0) begin
                    r_next.ale = 1'b1;
                    r_next.oe = 1'b1;
                    r_next.dout = nfc_addr_byte(r_reg.idx, r_reg.req);
                end
                if (wr_last) begin
                    r_next.cnt = 5'd0;
                    r_next.ale = 1'b0;
                    r_next.idx = r_reg.idx + 3'd1;
                    if (r_reg.idx == ADDR_LAST) begin
                        r_next.st = (is_prog && r_reg.req.len != 13'h0000) ? S_DATA : S_CMD2;
                    end
                end
            end
            S_DATA: begin
                if (r_reg.cnt == 5'd0) begin
                    if (fifo_valid) begin
                        fifo_pop = 1'b1;
                        r_next.oe = 1'b1;
                        r_next.dout = fifo_data;
                    end else begin
                        // Starved: hold the strobe high and retry next cycle
                        r_next.cnt = 5'd0;
                        r_next.we_n = 1'b1;
                    end
                end
                if (wr_last) begin
                    r_next.cnt = 5'd0;
                    r_next.nbytes = r_reg.nbytes + 13'h0001;
                    if (r_reg.nbytes == r_reg.req.len - 13'h0001) begin
                        r_next.st = S_CMD2;
                    end
                end
            end
            S_CMD2: begin
                if (r_reg.cnt == 5'd0) begin
                    r_next.cle = 1'b1;
                    r_next.oe = 1'b1;
                    r_next.dout = nfc_second_cmd(r_reg.req.op);
                end
                if (wr_last) begin
                    r_next.cnt = 5'd0;
                    r_next.cle = 1'b0;
                    r_next.oe = 1'b0;
                    r_next.st = S_WB;
                end
            end
            S_WB: begin
                // Busy may take up to this long to appear after the confirm edge
                if (r_reg.cnt == WB_CYC - 5'd1) begin
                    r_next.cnt = 5'd0;
                    r_next.st = S_RDY;
                end
            end
            S_RDY: begin
                // Strobes stay high and chip select low through busy
                r_next.cnt = 5'd0;
                if (r_reg.rb_s2) begin
                    r_next.nbytes = 13'h0000;
                    r_next.st = (r_reg.req.op == OP_READ && r_reg.req.len != 13'h0000) ? S_READ : S_DONE;
                end
            end
            S_WHR: begin
                if (r_reg.cnt == WHR_CYC - 5'd1) begin
                    r_next.cnt = 5'd0;
                    r_next.st = S_READ;
                end
            end
            S_READ: begin
                r_next.oe = 1'b0;
                if (r_reg.cnt == 5'd0) begin
                    r_next.re_n = 1'b0;
                end
                if (r_reg.cnt == R_LO_CYC) begin
                    r_next.re_n = 1'b1;
                    r_next.rdat = r_reg.io_s2;
                    r_next.rval = 1'b1;
                end
                if (rd_end) begin
                    r_next.cnt = 5'd0;
                    r_next.nbytes = r_reg.nbytes + 13'h0001;
                    if (is_status || r_reg.nbytes == r_reg.req.len - 13'h0001) begin
                        r_next.st = S_DONE;
                    end
                end
            end
            S_DONE: begin
                r_next.ce_n = 1'b1;
                r_next.done = 1'b1;
                r_next.idle = 1'b1;
                r_next.st = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            r_reg <= '0;
            r_reg.ce_n <= 1'b1;
            r_reg.we_n <= 1'b1;
            r_reg.re_n <= 1'b1;
            r_reg.idle <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign req_ready_out = r_reg.idle;
    assign done_out = r_reg.done;
    assign rd_valid_out = r_reg.rval;
    assign rd_data_out = r_reg.rdat;
    assign nand_ce_n_out = r_reg.ce_n;
    assign nand_cle_out = r_reg.cle;
    assign nand_ale_out = r_reg.ale;
    assign nand_we_n_out = r_reg.we_n;
    assign read_strobe_n_out = r_reg.re_n;
    assign nand_wp_n_out = r_reg.wp_n;
    assign port_lines_out = r_reg.dout;
    assign port_lines_oe_out = r_reg.oe;
endmodule
`default_nettype wire

// *** tb/nfc_ctrl_assertions.sv ***
`default_nettype none
module nfc_ctrl_checker (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Watched ports
    input wire logic req_ready_out,
    input wire logic done_out,
    input wire logic rd_valid_out,
    input wire logic nand_ce_n_out,
    input wire logic nand_cle_out,
    input wire logic nand_ale_out,
    input wire logic nand_we_n_out,
    input wire logic read_strobe_n_out,
    input wire logic port_lines_oe_out,
    input wire logic [7:0] port_lines_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);
    a_idle_deselect: assert property (req_ready_out |-> nand_ce_n_out && nand_we_n_out && read_strobe_n_out)
        else $error("chip select or strobe active while idle");
    a_ce_held_busy: assert property (!req_ready_out |-> !nand_ce_n_out)
        else $error("chip select released during a request");
    a_latch_exclusive: assert property (!nand_we_n_out |-> !(nand_cle_out && nand_ale_out))
        else $error("command and address latch both high");
    a_we_low_width: assert property ($fell(nand_we_n_out) |-> (!nand_we_n_out) [*3] ##1 nand_we_n_out)
        else $error("write strobe low phase not three cycles");
    a_we_high_gap: assert property ($rose(nand_we_n_out) |-> nand_we_n_out [*2])
        else $error("write strobe high phase too short");
    a_write_stable: assert property (!nand_we_n_out && !$past(nand_we_n_out) |->
        $stable(port_lines_out) && $stable(nand_cle_out) && $stable(nand_ale_out))
        else $error("port or latch changed inside write pulse");
    a_read_no_drive: assert property (!read_strobe_n_out |-> !port_lines_oe_out && !nand_cle_out && !nand_ale_out)
        else $error("port driven or latch high during read");
    a_strobe_exclusive: assert property (!(!nand_we_n_out && !read_strobe_n_out))
        else $error("both strobes low");
    a_rd_pulse_edge: assert property (rd_valid_out == $rose(read_strobe_n_out))
        else $error("read pulse not tied to read strobe rise");
    a_done_deselect: assert property (done_out |-> $rose(nand_ce_n_out) && req_ready_out)
        else $error("done without chip deselect");
endmodule
bind nfc_ctrl nfc_ctrl_checker i_chk (.core_clk_in(core_clk_in), .rst_in(rst_in), .req_ready_out(req_ready_out),
    .done_out(done_out), .rd_valid_out(rd_valid_out), .nand_ce_n_out(nand_ce_n_out), .nand_cle_out(nand_cle_out),
    .nand_ale_out(nand_ale_out), .nand_we_n_out(nand_we_n_out), .read_strobe_n_out(read_strobe_n_out),
    .port_lines_oe_out(port_lines_oe_out), .port_lines_out(port_lines_out));
`default_nettype wire

// *** tb/nfc_flash_model.sv ***
`default_nettype none
module nfc_flash_model
    import nfc_pkg::*;
(
    // Flash pins
    input wire logic ce_n_in,
    input wire logic cle_in,
    input wire logic ale_in,
    input wire logic we_n_in,
    input wire logic re_n_in,
    input wire logic wp_n_in,
    input wire logic [7:0] io_in,
    output logic [7:0] io_out,
    output logic rb_low_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [9:0] log_q[$];
    logic [12:0] col = 13'h0000;
    logic [16:0] row = 17'h00000;
    logic [2:0] idx = 3'h0;
    logic [7:0] nxt;
    logic stat_mode = 1'b0;
    logic standby;
    int busy_count = 0;
    initial io_out = 8'h00;
    initial rb_low_out = 1'b0;
    // Busy rises inside the controller's tWB wait, never after it
    task automatic run_busy(input int ns);
        #50;
        rb_low_out = 1'b1;
        busy_count++;
        #(ns);
        rb_low_out = 1'b0;
    endtask
    assign standby = ce_n_in && !rb_low_out;
    always @(posedge we_n_in) begin
        if (!ce_n_in && cle_in) begin
            log_q.push_back({2'b10, io_in});
            idx = 3'h0;
            stat_mode = (io_in == CMD_STATUS) || (io_in == CMD_STATUS_MP);
            if ((io_in == CMD_CONFIRM || io_in == CMD_CONFIRM_CACHE || io_in == CMD_ERASE_2) && wp_n_in) begin
                fork
                    run_busy(io_in == CMD_CONFIRM_CACHE ? 200 : 800);
                join_none
            end else if (io_in == CMD_READ_2 || io_in == CMD_RESET) begin
                fork
                    run_busy(300);
                join_none
            end
        end else if (!ce_n_in && ale_in) begin
            log_q.push_back({2'b01, io_in});
            case (idx)
                3'h0: col[7:0] = io_in;
                3'h1: col[12:8] = io_in[4:0];
                3'h2: row[7:0] = io_in;
                3'h3: row[15:8] = io_in;
                default: row[16] = io_in[0];
            endcase
            idx = idx + 3'h1;
        end else if (!ce_n_in) begin
            log_q.push_back({2'b00, io_in});
        end
    end
    always @(negedge re_n_in) begin
        if (!ce_n_in) begin
            // Ready sits on the sixth port line, write protect on the eighth
            nxt = stat_mode ? {wp_n_in, 1'b0, !rb_low_out, 5'h00} : col[7:0] ^ 8'hA5;
            if (!stat_mode) col = (col + 13'h0001) % 13'(PAGE_BYTES);
            #15;
            io_out = nxt;
        end
    end
    // Released lines show the inverse so a stale sample cannot pass
    always @(posedge re_n_in) io_out = ~io_out;
endmodule
`default_nettype wire

// *** tb/nfc_ctrl_tb_top.sv ***
`default_nettype none
module nfc_ctrl_tb_top;
    import nfc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic req_valid_in = 1'b0;
    nfc_req_t req_in = '0;
    logic write_enable_in = 1'b1;
    logic wr_valid_in = 1'b0;
    logic [7:0] wr_data_in = 8'h00;
    logic req_ready_out, done_out, wr_ready_out, rd_valid_out, nand_ce_n_out, nand_cle_out, nand_ale_out;
    logic nand_we_n_out, read_strobe_n_out, nand_wp_n_out, port_lines_oe_out, rb_low;
    logic [7:0] rd_data_out, port_lines_out, flash_io;
    logic [7:0] rd_q[$];
    int failures = 0;
    int total_checks = 0;
    wire [7:0] port_lines_in = port_lines_oe_out ? port_lines_out : flash_io;
    wire ready_busy_n_in = rb_low ? 1'b0 : 1'b1;
    always #2.5 core_clk_in = ~core_clk_in;
    nfc_ctrl i_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in), .req_in(req_in),
        .req_ready_out(req_ready_out), .done_out(done_out), .write_enable_in(write_enable_in),
        .wr_valid_in(wr_valid_in), .wr_ready_out(wr_ready_out), .wr_data_in(wr_data_in),
        .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out), .nand_ce_n_out(nand_ce_n_out),
        .nand_cle_out(nand_cle_out), .nand_ale_out(nand_ale_out), .nand_we_n_out(nand_we_n_out),
        .read_strobe_n_out(read_strobe_n_out), .nand_wp_n_out(nand_wp_n_out), .port_lines_out(port_lines_out),
        .port_lines_oe_out(port_lines_oe_out), .port_lines_in(port_lines_in), .ready_busy_n_in(ready_busy_n_in));
    nfc_flash_model i_flash (.ce_n_in(nand_ce_n_out), .cle_in(nand_cle_out), .ale_in(nand_ale_out),
        .we_n_in(nand_we_n_out), .re_n_in(read_strobe_n_out), .wp_n_in(nand_wp_n_out), .io_in(port_lines_in),
        .io_out(flash_io), .rb_low_out(rb_low));
    // Read pulse lasts one cycle, so the falling edge sees it settled
    always @(negedge core_clk_in) if (rd_valid_out === 1'b1) rd_q.push_back(rd_data_out);
    task automatic tick();
        @(posedge core_clk_in);
        #1;
    endtask
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        if (failures == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic do_req(input nfc_op_t op, input logic [12:0] col, input logic [16:0] row, input logic [12:0] len);
        int n = 0;
        i_flash.log_q.delete();
        rd_q.delete();
        req_in = '{op: op, column_bits: col, row: row, len: len};
        req_valid_in = 1'b1;
        tick();
        req_valid_in = 1'b0;
        while (done_out !== 1'b1 && n < 5000) begin
            tick();
            n++;
        end
        if (n == 5000) begin
            failures++;
            $display("mismatch at %0t: request never completed", $time);
        end
    endtask
    task automatic t_fifo_prog();
        int base;
        base = i_flash.busy_count;
        wr_valid_in = 1'b1;
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            wr_data_in = 8'(i);
            tick();
        end
        chk({9'h000, wr_ready_out}, 10'h000);
        wr_data_in = 8'hEE;
        tick();
        wr_valid_in = 1'b0;
        do_req(OP_PROG, 13'h1ABC, 17'h15A3C, 13'(FIFO_DEPTH));
        chk(i_flash.log_q.pop_front(), 10'h280);
        chk(i_flash.log_q.pop_front(), 10'h1BC);
        chk(i_flash.log_q.pop_front(), 10'h11A);
        chk(i_flash.log_q.pop_front(), 10'h13C);
        chk(i_flash.log_q.pop_front(), 10'h15A);
        chk(i_flash.log_q.pop_front(), 10'h101);
        for (int i = 0; i < FIFO_DEPTH; i++) chk(i_flash.log_q.pop_front(), 10'(i));
        chk(i_flash.log_q.pop_front(), 10'h210);
        chk(10'(i_flash.busy_count - base), 10'h001);
        chk({9'h000, wr_ready_out}, 10'h001);
    endtask
    task automatic t_read();
        do_req(OP_READ, 13'h0FFE, 17'h00041, 13'h0004);
        chk(i_flash.log_q[0], 10'h200);
        chk(i_flash.log_q[6], 10'h230);
        chk(10'(rd_q.size()), 10'h004);
        for (int i = 0; i < 4; i++) chk({2'b00, rd_q[i]}, {2'b00, 8'(13'h0FFE + 13'(i)) ^ 8'hA5});
        chk({9'h000, i_flash.standby}, 10'h001);
    endtask
    task automatic t_erase_wp();
        int base;
        write_enable_in = 1'b0;
        repeat (4) tick();
        base = i_flash.busy_count;
        do_req(OP_ERASE, 13'h0000, 17'h0ABC0, 13'h0000);
        chk(10'(i_flash.busy_count - base), 10'h000);
        write_enable_in = 1'b1;
        repeat (30) tick();
        do_req(OP_ERASE, 13'h0000, 17'h0ABC0, 13'h0000);
        chk(i_flash.log_q[1], 10'h1C0);
        chk(i_flash.log_q[4], 10'h2D0);
        chk(10'(i_flash.busy_count - base), 10'h001);
    endtask
    // Cached series are closed by a status poll and a reset
    task automatic t_cmd_table();
        nfc_op_t ops[8] = '{OP_PROG_CACHE, OP_STATUS, OP_RESET, OP_PROG_MP_CACHE, OP_STATUS_MP, OP_RESET,
            OP_PROG_MP, OP_PROG};
        logic [7:0] first[8] = '{8'h80, 8'h70, 8'hFF, 8'h81, 8'h71, 8'hFF, 8'h81, 8'h80};
        logic [7:0] last[8] = '{8'h15, 8'h70, 8'hFF, 8'h15, 8'h71, 8'hFF, 8'h10, 8'h10};
        for (int i = 0; i < 8; i++) begin
            if (first[i] != last[i]) begin
                wr_valid_in = 1'b1;
                wr_data_in = 8'h40 + 8'(i);
                tick();
                wr_valid_in = 1'b0;
            end
            do_req(ops[i], 13'h0005, 17'h00080, 13'h0001);
            chk(i_flash.log_q[0], {2'b10, first[i]});
            chk(i_flash.log_q[$], {2'b10, last[i]});
            if (first[i] != last[i]) chk(i_flash.log_q[6], {2'b00, 8'h40 + 8'(i)});
            if (first[i] == 8'h70 || first[i] == 8'h71) chk({2'b00, rd_q[0] & 8'hA0}, 10'h0A0);
        end
    endtask
    initial begin
        repeat (20) @(posedge core_clk_in);
        #1;
        rst_in = 1'b0;
        t_fifo_prog();
        t_read();
        t_erase_wp();
        t_cmd_table();
        end_sim();
    end
    initial begin
        #300us;
        failures++;
        $display("mismatch at %0t: watchdog expired", $time);
        end_sim();
    end
endmodule
`default_nettype wire
